// *** dbs_ctrl_model.sv ***
// Memory controller model driving the link pins of dbs_port.
// Assumes the narrow configuration and free-running kclk/kclk_n.
`default_nettype none

module dbs_ctrl_model #(
	parameter int AW = 6
) (
	// Link clocks
	input  wire logic          kclk,
	input  wire logic          kclk_n,
	// Request and write pins
	output var  logic [AW-1:0] addr,
	output var  logic          wps_n,
	output var  logic          rps_n,
	output var  logic [17:0]   wd,
	output var  logic [1:0]    msk_n,
	// Read pins
	input  wire logic [17:0]   q_r,
	input  wire logic [17:0]   q_f,
	input  wire logic          v_r,
	input  wire logic          v_f
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		addr = '0;
		wps_n = 1'b1;
		rps_n = 1'b1;
		wd = '0;
		msk_n = 2'h3;
	end

	// Beats 0..3 on K, K#, K, K#; mask travels with its beat
	task automatic wr(input logic [AW-1:0] a, input logic [71:0] d, input logic [7:0] m);
		@(posedge kclk);
		#1 wps_n = 1'b0;
		addr = a;
		wd = d[17:0];
		msk_n = m[1:0];
		for (int i = 1; i < 4; i++) begin
			if (i[0]) @(posedge kclk); else @(posedge kclk_n);
			#1 wps_n = 1'b1;
			addr = ~a;
			wd = 18'(d >> (18 * i));
			msk_n = 2'(m >> (2 * i));
		end
		@(posedge kclk_n);
		#1 wd = ~wd;
		msk_n = ~msk_n;
	endtask

	// Garbage on data and address with both ports deselected
	task automatic junk(input logic [AW-1:0] a);
		repeat (4) begin
			@(posedge kclk_n);
			#1 wd = ~wd;
			addr = a;
			msk_n = 2'h0;
		end
		@(posedge kclk);
		#1 addr = ~a;
	endtask

	// One read; sh selects the short (loop off) latency
	task automatic rd(input logic [AW-1:0] a, input logic sh, output logic [71:0] q,
			output logic ok);
		ok = 1'b1;
		@(posedge kclk);
		#1 rps_n = 1'b0;
		addr = a;
		@(posedge kclk);
		#1 rps_n = 1'b1;
		addr = ~a;
		if (!sh) repeat (2) @(posedge kclk);
		for (int i = 0; i < 5; i++) begin
			if (i[0] ^ sh) @(posedge kclk); else @(posedge kclk_n);
			#1;
			if (i < 4) q[18*i +: 18] = (i[0] ^ sh) ? q_r : q_f;
			ok = ok & ((i < 4) == ((i[0] ^ sh) ? v_r : v_f));
		end
	endtask
endmodule

`default_nettype wire

// *** dbs_fall_stage.sv ***
// Negative-clock half of the double-rate pins: samples inputs and launches outputs.
// Assumes launch data is stable from the preceding positive edge.
`default_nettype none

module dbs_fall_stage
	import dbs_pkg::*;
#(
	parameter int IN_W  = 20,
	parameter int OUT_W = 22
) (
	// Clock and reset
	input  wire logic             kclk_n,
	input  wire logic             rst_link,
	// Inputs sampled on the negative clock
	input  wire logic [IN_W-1:0]  cap_in,
	output var  logic [IN_W-1:0]  cap_out,
	// Outputs launched on the negative clock
	input  wire logic [OUT_W-1:0] launch_in,
	output var  logic [OUT_W-1:0] launch_out
);

	typedef struct packed {
		logic [IN_W-1:0]  cap;
		logic [OUT_W-1:0] launch;
	} dbs_fall_s;

	dbs_fall_s cur;
	dbs_fall_s next_cur;

	always_comb begin
		next_cur        = cur;
		next_cur.cap    = cap_in;
		next_cur.launch = launch_in;
		if (rst_link) begin
			next_cur = '0;
		end
	end

	always_ff @(posedge kclk_n) begin
		cur <= next_cur;
	end

	assign cap_out    = cur.cap;
	assign launch_out = cur.launch;

endmodule

`default_nettype wire

// *** dbs_pkg.sv ***
// Shared constants and types for the burst memory port.
// Assumes a link clock pair (positive and negative) from the controller.
`default_nettype none

package dbs_pkg;

	// Organisation
	localparam int LANE_W      = 9;
	localparam int BURST_LEN   = 4;
	localparam int BEAT_W      = 2;
	localparam int DATA_W_NARROW = 18;
	localparam int DATA_W_WIDE   = 36;
	localparam int ADDR_W_NARROW = 21;
	localparam int ADDR_W_WIDE   = 20;
	localparam int ADDR_MAX_W    = 21;
	localparam int COUNT_W       = 16;

	// Beat positions inside a burst
	localparam logic [1:0] BEAT_0 = 2'h0;
	localparam logic [1:0] BEAT_1 = 2'h1;
	localparam logic [1:0] BEAT_2 = 2'h2;
	localparam logic [1:0] BEAT_3 = 2'h3;

	// Highest link rate with the loop switched off, in MHz
	localparam int LOOP_OFF_MAX_MHZ = 167;

	// Reset values
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

	typedef enum logic [1:0] {
		WR_IDLE   = 2'b00,
		WR_FIRST  = 2'b01,
		WR_SECOND = 2'b11
	} dbs_wr_e;

	typedef struct packed {
		logic                  valid;
		logic [ADDR_MAX_W-1:0] addr;
	} dbs_req_s;

endpackage

`default_nettype wire

// *** dbs_port.sv ***
// Separate-I/O double-rate burst memory: write port, read port, array and echo.
// Assumes kclk and kclk_n are a complementary pair; double-rate pins are
// presented as rise/fall pairs that an output cell merges onto the pad.
`default_nettype none

// Functional notes
// - Write data captured on both clock edges.
// - Write select sampled on positive edge starts write.
// - Deselected write port ignores write data.
// - Lane masks sampled each beat; masked bytes unchanged.
// - Each mask governs one nine-bit lane.
// - One shared address bus sampled on positive edge.
// - Four sub-arrays; 21 or 20 address bits.
// - Address ignored when its port deselected.
// - Read data launched on both clock edges.
// - Read select sampled on positive edge starts read.
// - Deselect finishes pending read, then drivers off.
// - Each read returns four sequential words.
// - Valid flag marks read data, aligned with echo.
// - Accesses start only on positive clock edge.
// - Negative clock captures inputs and launches data.
// - Free-running echo strobes follow positive clock.
// - Loop off gives timing one and a half cycles earlier.
module dbs_port
	import dbs_pkg::*;
#(
	parameter int DATA_W = DATA_W_NARROW,
	parameter int ADDR_W = ADDR_W_NARROW
) (
	// System clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// Link clocks
	input  wire logic                     kclk,
	input  wire logic                     kclk_n,
	// Request pins
	input  wire logic [ADDR_W-1:0]        addr,
	input  wire logic                     write_port_select_n,
	input  wire logic                     read_port_select_n,
	input  wire logic                     loop_off_select,
	// Write data pins
	input  wire logic [DATA_W-1:0]        write_data,
	input  wire logic [DATA_W/LANE_W-1:0] byte_lane_mask_n,
	// Read data pins, positive-edge half
	output var  logic [DATA_W-1:0]        read_data_rise,
	output var  logic                     read_out_en_rise,
	output var  logic                     output_valid_flag_rise,
	output var  logic                     echo_strobe_rise,
	output var  logic                     echo_strobe_n_rise,
	// Read data pins, negative-edge half
	output var  logic [DATA_W-1:0]        read_data_fall,
	output var  logic                     read_out_en_fall,
	output var  logic                     output_valid_flag_fall,
	output var  logic                     echo_strobe_fall,
	output var  logic                     echo_strobe_n_fall,
	// Activity counts, system clock
	output var  logic [COUNT_W-1:0]       write_count,
	output var  logic [COUNT_W-1:0]       read_count
);

	localparam int LANES  = DATA_W / LANE_W;
	localparam int IDX_W  = ADDR_W + BEAT_W;
	localparam int DEPTH  = BURST_LEN << ADDR_W;
	localparam int IN_W   = DATA_W + LANES;
	localparam int OUT_W  = DATA_W + 4;

	// Link-domain state
	typedef struct packed {
		logic                    rst_s1;
		logic                    rst_s2;
		logic                    loop_s1;
		logic                    loop_s2;
		dbs_wr_e                 wr_st;
		logic [ADDR_W-1:0]       wr_addr;
		logic [DATA_W-1:0]       wr_hold;
		logic [LANES-1:0]        wr_hold_mask_n;
		dbs_req_s [3:0]          req;
		logic [DATA_W-1:0]       q_rise;
		logic                    v_rise;
		logic                    echo;
		logic                    echo_n;
		logic [DATA_W-1:0]       q_fall_pend;
		logic                    v_fall_pend;
		logic                    wr_tgl;
		logic                    rd_tgl;
	} dbs_link_s;

	// System-domain state
	typedef struct packed {
		logic               wr_s1;
		logic               wr_s2;
		logic               wr_s3;
		logic               rd_s1;
		logic               rd_s2;
		logic               rd_s3;
		logic [COUNT_W-1:0] wr_cnt;
		logic [COUNT_W-1:0] rd_cnt;
	} dbs_sys_s;

	dbs_link_s lnk;
	dbs_link_s next_lnk;
	dbs_sys_s  sys;
	dbs_sys_s  next_sys;

	logic [DATA_W-1:0] mem [0:DEPTH-1];

	logic              mem_we;
	logic [IDX_W-1:0]  mem_idx0;
	logic [IDX_W-1:0]  mem_idx1;
	logic [DATA_W-1:0] mem_data0;
	logic [DATA_W-1:0] mem_data1;
	logic [LANES-1:0]  mem_mask0_n;
	logic [LANES-1:0]  mem_mask1_n;

	logic [IN_W-1:0]   fall_cap;
	logic [OUT_W-1:0]  fall_launch;
	logic [DATA_W-1:0] fall_data;
	logic [LANES-1:0]  fall_mask_n;

	assign fall_data   = fall_cap[DATA_W-1:0];
	assign fall_mask_n = fall_cap[IN_W-1:DATA_W];

	function automatic logic [IDX_W-1:0] word_idx(
		input logic [ADDR_MAX_W-1:0] a,
		input logic [1:0]            beat
	);
		word_idx = {a[ADDR_W-1:0], beat};
	endfunction

	// Negative-clock capture and launch
	dbs_fall_stage #(
		.IN_W  (IN_W),
		.OUT_W (OUT_W)
	) u_fall (
		.kclk_n     (kclk_n),
		.rst_link   (lnk.rst_s2),
		.cap_in     ({byte_lane_mask_n, write_data}),
		.cap_out    (fall_cap),
		.launch_in  ({lnk.q_fall_pend, lnk.v_fall_pend, lnk.v_fall_pend,
			1'b0, lnk.echo}),
		.launch_out (fall_launch)
	);

	assign read_data_fall         = fall_launch[OUT_W-1:4];
	assign output_valid_flag_fall = fall_launch[3];
	assign read_out_en_fall       = fall_launch[2];
	assign echo_strobe_fall       = fall_launch[1];
	assign echo_strobe_n_fall     = fall_launch[0];

	// Link-side next state
	always_comb begin
		logic        wr_start;
		logic        loop_on;
		dbs_req_s    a1;
		dbs_req_s    a2;
		dbs_req_s    a3;
		dbs_req_s    a4;
		wr_start    = 1'b0;
		loop_on     = 1'b0;
		a1          = '0;
		a2          = '0;
		a3          = '0;
		a4          = '0;
		next_lnk    = lnk;
		mem_we      = 1'b0;
		mem_idx0    = '0;
		mem_idx1    = '0;
		mem_data0   = '0;
		mem_data1   = '0;
		mem_mask0_n = '1;
		mem_mask1_n = '1;

		// Reset and loop select come from other domains: two flops each
		next_lnk.rst_s1  = rst;
		next_lnk.rst_s2  = lnk.rst_s1;
		next_lnk.loop_s1 = loop_off_select;
		next_lnk.loop_s2 = lnk.loop_s1;
		loop_on          = lnk.loop_s2;

		// Write port: beats at K, K#, K, K# from the select edge
		// A select one edge after a start would overlap beat 2 and is dropped
		wr_start = !write_port_select_n && (lnk.wr_st != WR_FIRST);
		case (lnk.wr_st)
			WR_FIRST: begin
				mem_we         = 1'b1;
				mem_idx0       = {lnk.wr_addr, BEAT_0};
				mem_data0      = lnk.wr_hold;
				mem_mask0_n    = lnk.wr_hold_mask_n;
				mem_idx1       = {lnk.wr_addr, BEAT_1};
				mem_data1      = fall_data;
				mem_mask1_n    = fall_mask_n;
				next_lnk.wr_hold        = write_data;
				next_lnk.wr_hold_mask_n = byte_lane_mask_n;
				next_lnk.wr_st          = WR_SECOND;
			end
			WR_SECOND: begin
				mem_we         = 1'b1;
				mem_idx0       = {lnk.wr_addr, BEAT_2};
				mem_data0      = lnk.wr_hold;
				mem_mask0_n    = lnk.wr_hold_mask_n;
				mem_idx1       = {lnk.wr_addr, BEAT_3};
				mem_data1      = fall_data;
				mem_mask1_n    = fall_mask_n;
				next_lnk.wr_st = WR_IDLE;
			end
			default: begin
				next_lnk.wr_st = WR_IDLE;
			end
		endcase
		if (wr_start) begin
			next_lnk.wr_st          = WR_FIRST;
			next_lnk.wr_addr        = addr;
			next_lnk.wr_hold        = write_data;
			next_lnk.wr_hold_mask_n = byte_lane_mask_n;
			next_lnk.wr_tgl         = !lnk.wr_tgl;
		end

		// Read request pipeline, one stage per positive edge
		next_lnk.req[3]       = lnk.req[2];
		next_lnk.req[2]       = lnk.req[1];
		next_lnk.req[1]       = lnk.req[0];
		next_lnk.req[0].valid = !read_port_select_n;
		next_lnk.req[0].addr  = '0;
		if (!read_port_select_n) begin
			next_lnk.req[0].addr = ADDR_MAX_W'(addr);
			next_lnk.rd_tgl      = !lnk.rd_tgl;
		end
		a1 = lnk.req[0];
		a2 = lnk.req[1];
		a3 = lnk.req[2];
		a4 = lnk.req[3];

		// Beat scheduling; idle slots release the drivers
		// Array read at the launch edge; a write landing there is not yet seen
		next_lnk.v_rise      = 1'b0;
		next_lnk.v_fall_pend = 1'b0;
		next_lnk.q_rise      = '0;
		next_lnk.q_fall_pend = '0;
		if (!loop_on) begin
			if (a1.valid) begin
				next_lnk.q_rise      = mem[word_idx(a1.addr, BEAT_0)];
				next_lnk.v_rise      = 1'b1;
				next_lnk.q_fall_pend = mem[word_idx(a1.addr, BEAT_1)];
				next_lnk.v_fall_pend = 1'b1;
			end
			if (a2.valid) begin
				next_lnk.q_rise      = mem[word_idx(a2.addr, BEAT_2)];
				next_lnk.v_rise      = 1'b1;
				next_lnk.q_fall_pend = mem[word_idx(a2.addr, BEAT_3)];
				next_lnk.v_fall_pend = 1'b1;
			end
		end else begin
			if (a2.valid) begin
				next_lnk.q_fall_pend = mem[word_idx(a2.addr, BEAT_0)];
				next_lnk.v_fall_pend = 1'b1;
			end
			if (a3.valid) begin
				next_lnk.q_rise      = mem[word_idx(a3.addr, BEAT_1)];
				next_lnk.v_rise      = 1'b1;
				next_lnk.q_fall_pend = mem[word_idx(a3.addr, BEAT_2)];
				next_lnk.v_fall_pend = 1'b1;
			end
			if (a4.valid) begin
				next_lnk.q_rise      = mem[word_idx(a4.addr, BEAT_3)];
				next_lnk.v_rise      = 1'b1;
			end
		end

		next_lnk.echo = 1'b1;
		next_lnk.echo_n = 1'b0;

		// Link reset follows rst through two flops; the array keeps its contents
		if (lnk.rst_s2) begin
			next_lnk         = '0;
			next_lnk.rst_s1  = rst;
			next_lnk.rst_s2  = lnk.rst_s1;
			next_lnk.loop_s1 = loop_off_select;
			next_lnk.loop_s2 = lnk.loop_s1;
			next_lnk.wr_st   = WR_IDLE;
			mem_we           = 1'b0;
		end
	end

	always_ff @(posedge kclk) begin
		lnk <= next_lnk;
	end

	// Array write, two beats per positive edge, lane by lane
	always_ff @(posedge kclk) begin
		if (mem_we) begin
			for (int l = 0; l < LANES; l++) begin
				if (!mem_mask0_n[l]) begin
					mem[mem_idx0][l*LANE_W +: LANE_W] <= mem_data0[l*LANE_W +: LANE_W];
				end
				if (!mem_mask1_n[l]) begin
					mem[mem_idx1][l*LANE_W +: LANE_W] <= mem_data1[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	assign read_data_rise         = lnk.q_rise;
	assign output_valid_flag_rise = lnk.v_rise;
	assign read_out_en_rise       = lnk.v_rise;
	assign echo_strobe_rise       = lnk.echo;
	assign echo_strobe_n_rise     = lnk.echo_n;

	// System side: access events cross as toggles
	// Accesses closer than one system clock may merge or cancel in the count
	always_comb begin
		next_sys       = sys;
		next_sys.wr_s1 = lnk.wr_tgl;
		next_sys.wr_s2 = sys.wr_s1;
		next_sys.wr_s3 = sys.wr_s2;
		next_sys.rd_s1 = lnk.rd_tgl;
		next_sys.rd_s2 = sys.rd_s1;
		next_sys.rd_s3 = sys.rd_s2;
		if (sys.wr_s2 != sys.wr_s3) begin
			next_sys.wr_cnt = sys.wr_cnt + COUNT_W'(1);
		end
		if (sys.rd_s2 != sys.rd_s3) begin
			next_sys.rd_cnt = sys.rd_cnt + COUNT_W'(1);
		end
		if (rst) begin
			next_sys.wr_cnt = COUNT_RESET;
			next_sys.rd_cnt = COUNT_RESET;
		end
	end

	always_ff @(posedge mclk) begin
		sys <= next_sys;
	end

	assign write_count = sys.wr_cnt;
	assign read_count  = sys.rd_cnt;

endmodule

`default_nettype wire

// *** dbs_port_chk.sv ***
// Checker for the burst memory port, bound to dbs_port.
// Assumes the link side leaves reset within six kclk edges.
`default_nettype none

module dbs_port_chk
	import dbs_pkg::*;
#(
	parameter int DATA_W = 18
) (
	// Clocks and reset
	input wire logic               mclk,
	input wire logic               rst,
	input wire logic               kclk,
	// Selects
	input wire logic               read_port_select_n,
	input wire logic               loop_off_select,
	// Read side
	input wire logic [DATA_W-1:0]  read_data_rise,
	input wire logic               read_out_en_rise,
	input wire logic               read_out_en_fall,
	input wire logic               output_valid_flag_rise,
	input wire logic               output_valid_flag_fall,
	input wire logic               echo_strobe_rise,
	input wire logic               echo_strobe_fall,
	input wire logic               echo_strobe_n_rise,
	input wire logic               echo_strobe_n_fall,
	// Counts
	input wire logic [COUNT_W-1:0] write_count,
	input wire logic [COUNT_W-1:0] read_count
);
	timeunit 1ns;
	timeprecision 100ps;

	// Link reset lags rst through the synchroniser
	logic [5:0] rst_k;
	always_ff @(posedge kclk) begin
		rst_k <= {rst_k[4:0], rst};
	end
	wire logic k_off = rst || (|rst_k);

	AST_ECHO: assert property (@(posedge kclk) disable iff (k_off)
		echo_strobe_rise && echo_strobe_n_fall && !echo_strobe_fall && !echo_strobe_n_rise)
		else $error("echo strobes out of pattern");
	AST_VLD_EN: assert property (@(posedge kclk) disable iff (k_off)
		(output_valid_flag_rise == read_out_en_rise) && (output_valid_flag_fall == read_out_en_fall))
		else $error("valid flag differs from drive enable");
	AST_VLD_PAIR: assert property (@(posedge kclk) disable iff (k_off)
		$rose(output_valid_flag_fall) |-> ##1 output_valid_flag_rise)
		else $error("valid flag halves not paired");
	AST_IDLE_ZERO: assert property (@(posedge kclk) disable iff (k_off)
		!read_out_en_rise |-> read_data_rise == '0)
		else $error("read data not zero while idle");
	AST_LAT_ON: assert property (@(posedge kclk) disable iff (k_off)
		!read_port_select_n && loop_off_select |-> ##3 output_valid_flag_fall
		##1 (output_valid_flag_fall && output_valid_flag_rise) ##1 output_valid_flag_rise)
		else $error("loop on read beats misplaced");
	AST_LAT_OFF: assert property (@(posedge kclk) disable iff (k_off)
		!read_port_select_n && !loop_off_select |-> ##2 (read_out_en_rise && read_out_en_fall)
		##1 (read_out_en_rise && read_out_en_fall))
		else $error("loop off read beats misplaced");
	AST_DESEL_OFF: assert property (@(posedge kclk) disable iff (k_off)
		read_port_select_n [*6] |=> !read_out_en_rise && !read_out_en_fall)
		else $error("drivers on while deselected");
	AST_WR_CNT: assert property (@(posedge mclk) disable iff (rst)
		$changed(write_count) |-> write_count == $past(write_count) + 16'h0001)
		else $error("write count stepped wrongly");
	AST_RD_CNT: assert property (@(posedge mclk) disable iff (rst)
		$changed(read_count) |-> read_count == $past(read_count) + 16'h0001)
		else $error("read count stepped wrongly");
endmodule

bind dbs_port dbs_port_chk #(.DATA_W(DATA_W)) u_chk (.*);

`default_nettype wire

// *** dbs_port_test.sv ***
// Testbench for dbs_port: controller model on the link, counts on mclk.
// Assumes the narrow configuration with a 6-bit address.
`default_nettype none

module dbs_port_test;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [71:0] D1 = 72'h9a_5a5a_5a5a_5a5a_5a5a;
	localparam logic [71:0] D2 = 72'h36_c3c3_c3c3_c3c3_c3c3;
	localparam logic [7:0]  M2 = 8'h39;

	logic        mclk;
	logic        rst;
	logic        kclk;
	logic        loop_off_select;
	logic [71:0] q;
	logic [71:0] e;
	logic        ok;
	int          num_errors;
	int          n_checks;
	int          cyc;
	wire logic        kclk_n = ~kclk;
	wire logic [5:0]  addr;
	wire logic        wps_n;
	wire logic        rps_n;
	wire logic [17:0] wd;
	wire logic [1:0]  msk_n;
	wire logic [17:0] q_r;
	wire logic [17:0] q_f;
	wire logic        v_r;
	wire logic        v_f;
	wire logic [15:0] wcnt;
	wire logic [15:0] rcnt;

	dbs_port #(.DATA_W(18), .ADDR_W(6)) DUT (
		.mclk(mclk), .rst(rst), .kclk(kclk), .kclk_n(kclk_n), .addr(addr),
		.write_port_select_n(wps_n), .read_port_select_n(rps_n),
		.loop_off_select(loop_off_select), .write_data(wd), .byte_lane_mask_n(msk_n),
		.read_data_rise(q_r), .read_out_en_rise(), .output_valid_flag_rise(v_r),
		.echo_strobe_rise(), .echo_strobe_n_rise(), .read_data_fall(q_f),
		.read_out_en_fall(), .output_valid_flag_fall(v_f), .echo_strobe_fall(),
		.echo_strobe_n_fall(), .write_count(wcnt), .read_count(rcnt));

	dbs_ctrl_model #(.AW(6)) u_ctl (
		.kclk(kclk), .kclk_n(kclk_n), .addr(addr), .wps_n(wps_n), .rps_n(rps_n),
		.wd(wd), .msk_n(msk_n), .q_r(q_r), .q_f(q_f), .v_r(v_r), .v_f(v_f));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		kclk = 1'b0;
		#3;
		forever #6 kclk = ~kclk;
	end

	task automatic chk(input string nm, input logic [71:0] got, input logic [71:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic gap();
		repeat (20) @(posedge kclk);
	endtask

	task automatic s_burst();
		u_ctl.wr(6'h05, D1, 8'h00);
		gap();
		u_ctl.rd(6'h05, 1'b0, q, ok);
		chk("burst", q, D1);
		chk("valid", {71'h0, ok}, 72'h1);
		gap();
	endtask

	task automatic s_mask();
		u_ctl.wr(6'h05, D2, M2);
		for (int i = 0; i < 8; i++) e[9*i +: 9] = M2[i] ? D1[9*i +: 9] : D2[9*i +: 9];
		gap();
		u_ctl.rd(6'h05, 1'b0, q, ok);
		chk("masked", q, e);
		gap();
	endtask

	task automatic s_desel();
		u_ctl.junk(6'h05);
		gap();
		u_ctl.rd(6'h05, 1'b0, q, ok);
		chk("deselected", q, e);
		gap();
	endtask

	task automatic s_loop_off();
		#1 loop_off_select = 1'b0;
		gap();
		u_ctl.rd(6'h05, 1'b1, q, ok);
		chk("short burst", q, e);
		chk("short valid", {71'h0, ok}, 72'h1);
		loop_off_select = 1'b1;
		gap();
	endtask

	task automatic s_counts();
		gap();
		chk("writes", {56'h0, wcnt}, 72'h2);
		chk("reads", {56'h0, rcnt}, 72'h4);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		loop_off_select = 1'b1;
		repeat (4) @(posedge mclk);
		#1 rst = 1'b0;
		gap();
		s_burst();
		s_mask();
		s_desel();
		s_loop_off();
		s_counts();
		give_verdict();
	end
endmodule

`default_nettype wire
